/* rtl/mac_block.sv */
`timescale 1ns/1ps
// ************************************************************
// dual multiply-accumulate / two-multiplier adder slice
// ************************************************************
module mac_block #(
   parameter logic [1:0] MODE = mac_pkg::MODE_MAC, // block configuration
   parameter int SUB_STAGES = 1, // add/sub select register stages (0..1)
   parameter int LOAD_STAGES = 2, // load select register stages (0..2)
   parameter bit A_PARALLEL = 1'b1, // operand a loads in parallel
   parameter bit B_PARALLEL = 1'b1 // operand b loads in parallel
) (
   input wire logic clk, // 125 MHz clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [1:0][mac_pkg::OPND_W-1:0] a_in, // operand a per channel
   input wire logic [1:0][mac_pkg::OPND_W-1:0] b_in, // operand b per channel
   input wire logic [1:0] a_shift_in, // chained a from neighbour slice
   input wire logic [1:0] b_shift_in, // chained b from neighbour slice
   input wire logic [1:0] addnsub, // per channel: 1 add, 0 subtract
   input wire logic [1:0] acc_load, // per channel accumulator load
   output logic [1:0][mac_pkg::ACC_W-1:0] result, // accumulated or summed result
   output logic [1:0] overflow // overflow / underflow flag
);
   localparam int AW = mac_pkg::ACC_W;
   localparam int PW = mac_pkg::PROD_W;
   localparam int OW = mac_pkg::OPND_W;

   // ************************************************************
   // input registers: parallel load or serial shift chain
   // ************************************************************
   logic [1:0][OW-1:0] a_reg, b_reg; // operand registers
   logic [1:0][OW-1:0] next_a_reg, next_b_reg; // next operands

   // chained operands shift one bit a cycle; constants stay parallel
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         next_a_reg[c] = A_PARALLEL ? a_in[c] : {a_reg[c][OW-2:0], a_shift_in[c]};
         next_b_reg[c] = B_PARALLEL ? b_in[c] : {b_reg[c][OW-2:0], b_shift_in[c]};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         a_reg <= '0;
         b_reg <= '0;
      end else begin
         a_reg <= next_a_reg;
         b_reg <= next_b_reg;
      end
   end

   // ************************************************************
   // control pipelines
   // ************************************************************
   logic [1:0] sub_d1; // add/sub select after one stage
   logic [1:0] load_d1, load_d2; // load select after one and two stages
   logic [1:0] sub_sel, load_sel; // selected control per channel
   mac_pkg::acc_ctl_t [1:0] ctl; // bundled control per channel

   // staging keeps load aligned with product latency; add/sub has one stage less and takes the next beat's value
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sub_d1 <= 2'h0;
         load_d1 <= 2'h0;
         load_d2 <= 2'h0;
      end else begin
         sub_d1 <= ~addnsub;
         load_d1 <= acc_load;
         load_d2 <= load_d1;
      end
   end

   always_comb begin
      sub_sel = (SUB_STAGES == 0) ? ~addnsub : sub_d1;
      unique case (LOAD_STAGES)
         0: load_sel = acc_load;
         1: load_sel = load_d1;
         default: load_sel = load_d2;
      endcase
      for (int c = 0; c < 2; c++) begin
         ctl[c].sub = sub_sel[c];
         // load is absent outside accumulate mode
         ctl[c].load = (MODE == mac_pkg::MODE_MAC) ? load_sel[c] : 1'b0;
      end
   end

   // ************************************************************
   // multipliers: one per accumulator, both in use in every mode
   // ************************************************************
   logic [1:0][PW-1:0] prod; // registered signed products
   logic [1:0][PW-1:0] next_prod; // next products

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         next_prod[c] = PW'($signed(a_reg[c]) * $signed(b_reg[c]));
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) prod <= '0;
      else prod <= next_prod;
   end

   // ************************************************************
   // accumulator / adder stage
   // ************************************************************
   logic [1:0][AW-1:0] next_result; // next outputs
   logic [1:0] next_overflow; // next flags
   logic [1:0][AW-1:0] ext; // sign-extended products
   logic [AW:0] wide; // sum with carry guard for overflow check

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         ext[c] = {{(AW-PW){prod[c][PW-1]}}, prod[c]};
      end
      next_result = result;
      next_overflow = overflow;
      wide = '0;
      unique case (MODE)
         mac_pkg::MODE_MAC: begin
            for (int c = 0; c < 2; c++) begin
               if (ctl[c].load) begin
                  next_result[c] = ext[c];
                  next_overflow[c] = 1'b0;
               end else begin
                  wide = ctl[c].sub ? {result[c][AW-1], result[c]} - {ext[c][AW-1], ext[c]}
                                    : {result[c][AW-1], result[c]} + {ext[c][AW-1], ext[c]};
                  next_result[c] = wide[AW-1:0];
                  // sticky until reload; when subtracting this can be underflow or overflow
                  next_overflow[c] = overflow[c] | (wide[AW] ^ wide[AW-1]);
               end
            end
         end
         mac_pkg::MODE_ADD: begin
            // one combined output from both products
            next_result[0] = ctl[0].sub ? ext[0] - ext[1] : ext[0] + ext[1];
            next_result[1] = '0;
            next_overflow = 2'h0;
         end
         default: begin
            next_result = ext;
            next_overflow = 2'h0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result <= {2{mac_pkg::ACC_RST}};
         overflow <= 2'h0;
      end else begin
         result <= next_result;
         overflow <= next_overflow;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_load_restart;
      @(posedge clk) disable iff (sys_rst)
      (MODE == mac_pkg::MODE_MAC && ctl[0].load) |=> (result[0] == $past(ext[0]) && !overflow[0]);
   endproperty
   a_load_restart: assert property (p_load_restart) else $error("load did not restart accumulator");

   property p_accum_add;
      @(posedge clk) disable iff (sys_rst)
      (MODE == mac_pkg::MODE_MAC && !ctl[1].load && !ctl[1].sub)
         |=> result[1] == AW'($past(result[1]) + $past(ext[1]));
   endproperty
   a_accum_add: assert property (p_accum_add) else $error("accumulate add mismatch");

   // the subtract direction is checked on the other channel so both see a check
   property p_accum_sub;
      @(posedge clk) disable iff (sys_rst)
      (MODE == mac_pkg::MODE_MAC && !ctl[0].load && ctl[0].sub)
         |=> result[0] == AW'($past(result[0]) - $past(ext[0]));
   endproperty
   a_accum_sub: assert property (p_accum_sub) else $error("accumulate subtract mismatch");

   property p_no_ovf_other;
      @(posedge clk) disable iff (sys_rst)
      (MODE != mac_pkg::MODE_MAC) |=> overflow == 2'h0;
   endproperty
   a_no_ovf_other: assert property (p_no_ovf_other) else $error("overflow outside accumulate mode");

   property p_adder;
      @(posedge clk) disable iff (sys_rst)
      (MODE == mac_pkg::MODE_ADD) |=> result[0] == ($past(ctl[0].sub) ? AW'($past(ext[0]) - $past(ext[1]))
                                                     : AW'($past(ext[0]) + $past(ext[1])));
   endproperty
   a_adder: assert property (p_adder) else $error("adder mode sum wrong");

   // a load request seen two edges ago, only meaningful with two stages
   sequence s_load_seen;
      (LOAD_STAGES == 2 && acc_load[0]) ##2 1'b1;
   endsequence
   property p_load_latency;
      @(posedge clk) disable iff (sys_rst)
      s_load_seen |-> load_sel[0];
   endproperty
   a_load_latency: assert property (p_load_latency) else $error("load latency wrong");
endmodule // mac_block

/* rtl/mac_pkg.sv */
package mac_pkg;
   // ************************************************************
   // widths and configuration codes
   // ************************************************************
   localparam int OPND_W = 18; // operand width
   localparam int PROD_W = 36; // full product width
   localparam int HEAD_W = 16; // accumulation headroom
   localparam int ACC_W = 52; // accumulator width
   localparam logic [1:0] MODE_MAC = 2'h0; // two independent accumulators
   localparam logic [1:0] MODE_ADD = 2'h1; // two-multiplier adder
   localparam logic [1:0] MODE_MUL = 2'h2; // plain products
   localparam logic [ACC_W-1:0] ACC_RST = 52'h0; // accumulator reset value

   // per-accumulator control bundled together after the control pipelines
   typedef struct packed {
      logic load; // start from current product
      logic sub; // subtract rather than add
   } acc_ctl_t;
endpackage

/* sim/fabric_model.sv */
`timescale 1ns/1ps
// ************************************************************
// fabric-side operand source
// ************************************************************
module fabric_model (
   input wire logic clk, // bench clock
   output logic [1:0][mac_pkg::OPND_W-1:0] a_in, // operands a
   output logic [1:0][mac_pkg::OPND_W-1:0] b_in, // operands b
   output logic [1:0] addnsub, // direction per channel
   output logic [1:0] acc_load // restart per channel
);
   // idle values at time zero
   initial begin
      a_in = '0;
      b_in = '0;
      addnsub = 2'h3;
      acc_load = 2'h0;
   end
   // one beat launched on the falling edge, so half a period of setup
   task automatic put(input logic [1:0][17:0] a, input logic [1:0][17:0] b, input logic [1:0] s,
                      input logic [1:0] ld);
      @(negedge clk);
      a_in = a;
      b_in = b;
      addnsub = s;
      acc_load = ld;
   endtask
endmodule // fabric_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
// ************************************************************
// self-checking bench, default accumulate configuration
// ************************************************************
module tb_top;
   logic clk = 1'b0; // 125 MHz
   logic sys_rst = 1'b1; // synchronous reset
   logic [1:0][17:0] a_in, b_in; // operands from the fabric model
   logic [1:0] addnsub, acc_load; // controls from the fabric model
   logic [1:0][51:0] result; // accumulators
   logic [1:0] overflow; // sticky flags
   logic [1:0][51:0] exp_q[$]; // expected results, oldest first
   logic signed [51:0] acc [2]; // reference accumulators
   int fail_count = 0; // mismatches
   int n_checks = 0; // comparisons
   always #4 clk = ~clk;
   fabric_model u_fabric_model (.clk(clk), .a_in(a_in), .b_in(b_in), .addnsub(addnsub), .acc_load(acc_load));
   // shift inputs stay low: both operands are parallel here
   mac_block u_mac_block (.clk(clk), .sys_rst(sys_rst), .a_in(a_in), .b_in(b_in), .a_shift_in(2'h0),
      .b_shift_in(2'h0), .addnsub(addnsub), .acc_load(acc_load), .result(result), .overflow(overflow));
   // ************************************************************
   // monitor: results settle under zero operands, checked at negedge
   // ************************************************************
   // sampling away from the rising edge avoids racing the design's update
   always @(negedge clk) begin
      while (exp_q.size() > 0) begin
         logic [1:0][51:0] e;
         e = exp_q.pop_front();
         `CHK("result0", e[0], result[0])
         `CHK("result1", e[1], result[1])
         `CHK("overflow", 2'h0, overflow)
      end
   end
   // signed 18x18 product, sign extended to the accumulator width
   function automatic logic signed [51:0] mul(input logic [17:0] x, input logic [17:0] y);
      mul = 52'($signed(x)) * 52'($signed(y));
   endfunction
   // one run: settle direction, load, accumulate, drain
   task automatic run_test(input int t);
      logic [1:0][17:0] a, b;
      logic [1:0] s;
      int n;
      s = 2'($urandom);
      n = 1 + $urandom % 6;
      for (int c = 0; c < 2; c++) begin
         a[c] = 18'($urandom);
         b[c] = 18'($urandom);
         // a load takes the product as is, whichever way the channel counts
         acc[c] = mul(a[c], b[c]);
      end
      repeat (2) u_fabric_model.put('0, '0, s, 2'h0);
      u_fabric_model.put(a, b, s, 2'h3);
      repeat (n) begin
         for (int c = 0; c < 2; c++) begin
            a[c] = 18'($urandom);
            b[c] = 18'($urandom);
            acc[c] = s[c] ? acc[c] + mul(a[c], b[c]) : acc[c] - mul(a[c], b[c]);
         end
         u_fabric_model.put(a, b, s, 2'h0);
      end
      repeat (4) u_fabric_model.put('0, '0, s, 2'h0);
      exp_q.push_back({acc[1], acc[0]});
      @(negedge clk);
      $display("test %0d done", t);
   endtask
   // verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end
   // main sequence
   initial begin
      void'($urandom(32'hD3E272F8));
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      exp_q.push_back('0);
      @(negedge clk);
      for (int t = 0; t < 16; t++) run_test(t);
      // bounded drain: a note left on the queue counts as a mismatch
      for (int w = 0; w < 8 && exp_q.size() > 0; w++) @(posedge clk);
      if (exp_q.size() > 0) fail_count++;
      final_report();
   end
endmodule // tb_top
